// File: sim/tb.sv
// Purpose: Self-checking bench for the instruction decoder.
// Assumes: Words are driven 1 ns after the edge that shows cycle_start.
// Notes: A queue pairs each driven word with the next decoded cycle.
`timescale 1ns/1ps
module tb;
  import decode_pkg::*;
  typedef struct packed {logic idle; logic [11:0] w;} exp_t;
  logic              clk = 1'b0;
  logic              rst_b = 1'b0;
  logic [WORD_W-1:0] instr_word = 12'h000;
  logic              skip_true = 1'b0;
  logic [1:0]        group_code;
  logic [5:0]        opcode;
  logic              to_accum, to_register, cycle_start, idle_cycle, two_cycle, pc_load;
  logic [IDX_W-1:0]  reg_index;
  logic [POS_W-1:0]  bit_position;
  logic [K9_W-1:0]   immediate;
  exp_t              q[$];
  logic [31:0]       seed = 32'h5b;
  int                failures = 0;
  int                num_checks = 0;
  int                cnt = 0;
  logic              was_low = 1'b0;
  logic              prev_idle, prev_pc, prev_bb;
  instr_decode instr_decode_i (.clk(clk), .rst_b(rst_b), .instr_word(instr_word),
    .skip_true(skip_true), .group_code(group_code), .opcode(opcode), .to_accum(to_accum),
    .to_register(to_register), .reg_index(reg_index), .bit_position(bit_position),
    .immediate(immediate), .cycle_start(cycle_start), .idle_cycle(idle_cycle),
    .two_cycle(two_cycle), .pc_load(pc_load));
  always #20 clk = ~clk;
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [1:0] grp(input logic [11:0] w);
    if (w[11:8] <= TOP_BYTE3) return 2'h0;
    if (w[11:8] <= TOP_BTSTS) return 2'h1;
    return 2'h2;
  endfunction
  function automatic logic jumps(input logic [11:0] w);
    return (w[11:9] == TOP3_BRANCH) || (w[11:8] == TOP_CALL);
  endfunction
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic do_reset(input logic [11:0] w);
    @(posedge clk);
    #1;
    rst_b = 1'b0;
    q.delete();
    skip_true = 1'b0;
    instr_word = w;
    q.push_back({1'b0, w});
    {prev_idle, prev_pc, prev_bb} = {1'b0, jumps(w), grp(w) != 2'h2};
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk({8'h0, idle_cycle}, 9'h001);
    chk({7'h0, group_code}, 9'h002);
    chk({3'h0, opcode}, 9'h000);
    chk(immediate, 9'h000);
    @(posedge clk);
    #1;
    rst_b = 1'b1;
  endtask
  task automatic send(input logic [11:0] w);
    int          n;
    logic        sk, idle_now;
    logic [31:0] r;
    n = 0;
    @(posedge clk);
    #1;
    while (cycle_start !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 8) begin
      failures++;
      finish_test();
    end
    r  = xs();
    sk = r[0] & ~prev_idle;
    skip_true = sk;
    idle_now = ~prev_idle & (prev_pc | (sk & prev_bb));
    instr_word = w;
    q.push_back({idle_now, w});
    {prev_idle, prev_pc, prev_bb} = {idle_now, jumps(w), grp(w) != 2'h2};
  endtask
  // Outputs are settled at the falling edge; only a fresh cycle_start is compared.
  always @(negedge clk) begin
    exp_t e;
    if (rst_b !== 1'b1) begin
      cnt = 0;
      was_low = 1'b0;
    end else begin
      cnt++;
      if (cycle_start === 1'b1 && was_low) begin
        chk(9'(cnt), 9'h004);
        if (q.size() == 0) begin
          failures++;
          $display("Error at %0t: got %h expected %h", $time, 32'h0, 32'h1);
        end else begin
          e = q.pop_front();
          chk({8'h0, idle_cycle}, {8'h0, e.idle});
          if (!e.idle) begin
            chk({7'h0, group_code}, {7'h0, grp(e.w)});
            chk({3'h0, opcode}, {3'h0, e.w[11:6]});
            chk({2'h0, reg_index}, {4'h0, e.w[4:0]});
            chk({6'h0, bit_position}, {6'h0, e.w[7:5]});
            chk(immediate, (e.w[11:9] == TOP3_BRANCH) ? e.w[8:0] : {1'h0, e.w[7:0]});
            chk({8'h0, pc_load}, {8'h0, jumps(e.w)});
            if (grp(e.w) == 2'h0) begin
              chk({7'h0, to_accum, to_register}, {7'h0, ~e.w[5], e.w[5]});
            end
            if (e.w[11:9] != 3'h3 && e.w[11:6] != OP_DECSKIP && e.w[11:6] != OP_INCSKIP) begin
              chk({8'h0, two_cycle}, {8'h0, jumps(e.w)});
            end
          end
        end
      end
      if (cycle_start === 1'b1) cnt = 0;
      was_low = (cycle_start !== 1'b1);
    end
  end
  localparam logic [11:0] DIR [16] = '{12'h000, 12'h1ff, 12'h3df, 12'h41f, 12'h5e0, 12'h6a3,
    12'h7ff, 12'h9ab, 12'ha01, 12'hbff, 12'h2c5, 12'h3c0, 12'hc7f, 12'hd80, 12'he55, 12'h0b1};
  initial begin
    do_reset(12'h9ff);
    for (int i = 0; i < 16; i++) send(DIR[i]);
    repeat (3) send(12'ha10 + 12'(xs() & 32'h1f));
    $display("directed words done");
    for (int i = 0; i < 300; i++) send(12'(xs()));
    $display("random words done");
    do_reset(12'h5ff);
    for (int i = 0; i < 40; i++) send(12'(xs()));
    send(12'h000);
    send(12'h000);
    $display("reset rerun done");
    finish_test();
  end
endmodule

// File: verilog/decode_if.sv
`timescale 1ns/1ps
// Purpose: Carries the split fields from the field splitter to the core sequencer.
// Assumes: One clock domain.
// Notes: Pure combinational bundle.
interface decode_if;
  import decode_pkg::*;
  group_t           group;
  logic [5:0]       opcode;
  logic             target;
  logic [IDX_W-1:0] index;
  logic [POS_W-1:0] position;
  logic [K9_W-1:0]  constant;
  logic             is_branch;
  logic             is_call;
  logic             is_skip;
  modport split (output group, opcode, target, index, position, constant,
                 is_branch, is_call, is_skip);
  modport use_  (input group, opcode, target, index, position, constant,
                 is_branch, is_call, is_skip);
endinterface

// File: verilog/decode_pkg.sv
// Purpose: Constants and types for the twelve-bit instruction decoder.
// Assumes: Instruction words arrive from program memory on the core clock.
// Notes: Behaviour
package decode_pkg;
  localparam int          WORD_W       = 12;
  localparam int          IDX_W        = 7;
  localparam int          FIELD_IDX_W  = 5;
  localparam int          POS_W        = 3;
  localparam int          K8_W         = 8;
  localparam int          K9_W         = 9;
  localparam int          PHASE_W      = 2;
  localparam logic [1:0]  PHASE_LAST   = 2'h3;
  localparam int          IDX_LSB      = 0;
  localparam int          TGT_BIT      = 5;
  localparam int          POS_LSB      = 5;
  localparam int          K_LSB        = 0;
  localparam logic [11:0] NOP_WORD     = 12'h000;
  localparam logic [6:0]  IDX_MAX      = 7'h7f;
  // Top-nibble codes of the groups and of a call, the top three bits of a branch and the six-bit skip opcodes.
  localparam logic [3:0]  TOP_BYTE0    = 4'h0;
  localparam logic [3:0]  TOP_BYTE3    = 4'h3;
  localparam logic [3:0]  TOP_BCLR     = 4'h4;
  localparam logic [3:0]  TOP_BSET     = 4'h5;
  localparam logic [3:0]  TOP_BTSTC    = 4'h6;
  localparam logic [3:0]  TOP_BTSTS    = 4'h7;
  localparam logic [3:0]  TOP_CALL     = 4'h9;
  localparam logic [2:0]  TOP3_BRANCH  = 3'h5;
  localparam logic [5:0]  OP_DECSKIP   = 6'h0b;
  localparam logic [5:0]  OP_INCSKIP   = 6'h0f;
  typedef enum logic [1:0] {GRP_BYTE, GRP_BIT, GRP_LIT} group_t;
endpackage

// File: verilog/field_split.sv
`timescale 1ns/1ps
// Purpose: Splits a 12-bit instruction word into group and operand fields.
// Assumes: Word is stable for the instruction cycle.
// Notes: Combinational only.
module field_split
  import decode_pkg::*;
(
  // Instruction word
  input  wire logic [WORD_W-1:0] word,
  // Fields
  decode_if.split                f
);
  logic [3:0] top;
  assign top = word[11:8];

  always_comb begin
    f.opcode    = word[11:6];
    f.target    = word[TGT_BIT];
    // Index zero-extends into the 7-bit register space.
    f.index     = {2'h0, word[IDX_LSB +: FIELD_IDX_W]};
    f.position  = word[POS_LSB +: POS_W];
    f.is_branch = (word[11:9] == TOP3_BRANCH);
    f.is_call   = (top == TOP_CALL);
    // Branch takes 9 bits; other literal forms carry 8 and the ninth reads zero.
    if (f.is_branch) begin
      f.constant = word[K_LSB +: K9_W];
    end else begin
      f.constant = {1'b0, word[K_LSB +: K8_W]};
    end
    if (top <= TOP_BYTE3) begin
      f.group = GRP_BYTE;
    end else if (top <= TOP_BTSTS) begin
      f.group = GRP_BIT;
    end else begin
      f.group = GRP_LIT;
    end
    f.is_skip = (top == TOP_BTSTC) || (top == TOP_BTSTS) ||
                (word[11:6] == OP_DECSKIP) || (word[11:6] == OP_INCSKIP);
  end
endmodule

// File: verilog/instr_decode.sv
`timescale 1ns/1ps
// Purpose: Instruction decoder with phase counter and two-cycle sequencing.
// Assumes: Word is valid at the first phase; skip_true is valid at the last phase.
// Notes: Outputs other than cycle_start update at the end of each four-period instruction cycle.
module instr_decode
  import decode_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // Program memory
  input  wire logic [WORD_W-1:0] instr_word,
  // Datapath feedback
  input  wire logic              skip_true,
  // Decoded fields
  output logic [1:0]             group_code,
  output logic [5:0]             opcode,
  output logic                   to_accum,
  output logic                   to_register,
  output logic [IDX_W-1:0]       reg_index,
  output logic [POS_W-1:0]       bit_position,
  output logic [K9_W-1:0]        immediate,
  // Sequencing
  output logic                   cycle_start,
  output logic                   idle_cycle,
  output logic                   two_cycle,
  output logic                   pc_load
);
  decode_if f ();

  field_split u_split (
    .word (instr_word),
    .f    (f)
  );

  logic [PHASE_W-1:0] phase_reg;
  logic [PHASE_W-1:0] phase_next;
  logic               flush_reg;
  logic               flush_next;
  logic [1:0]         group_reg;
  logic [1:0]         group_next;
  logic [5:0]         opcode_reg;
  logic [5:0]         opcode_next;
  logic               acc_reg;
  logic               acc_next;
  logic               freg_reg;
  logic               freg_next;
  logic [IDX_W-1:0]   index_reg;
  logic [IDX_W-1:0]   index_next;
  logic [POS_W-1:0]   pos_reg;
  logic [POS_W-1:0]   pos_next;
  logic [K9_W-1:0]    imm_reg;
  logic [K9_W-1:0]    imm_next;
  logic               two_reg;
  logic               two_next;
  logic               pcl_reg;
  logic               pcl_next;
  logic               end_cycle;
  logic               discard;

  assign end_cycle = (phase_reg == PHASE_LAST);
  // The word fetched behind a branch, a call or a true test is dropped.
  assign discard   = !flush_reg && (pcl_reg || (skip_true && group_reg != GRP_LIT));

  always_comb begin
    phase_next     = phase_reg + 2'h1;
    flush_next     = flush_reg;
    group_next     = group_reg;
    opcode_next    = opcode_reg;
    acc_next       = acc_reg;
    freg_next      = freg_reg;
    index_next     = index_reg;
    pos_next       = pos_reg;
    imm_next       = imm_reg;
    two_next       = two_reg;
    pcl_next       = pcl_reg;
    if (end_cycle) begin
      // The second cycle of a two-cycle instruction discards the fetched word and runs idle.
      if (discard) begin
        flush_next     = 1'b1;
        group_next     = GRP_LIT;
        opcode_next    = NOP_WORD[11:6];
        acc_next       = 1'b0;
        freg_next      = 1'b0;
        index_next     = '0;
        pos_next       = '0;
        imm_next       = '0;
        two_next       = 1'b0;
        pcl_next       = 1'b0;
      end else begin
        flush_next  = 1'b0;
        group_next  = f.group;
        opcode_next = f.opcode;
        // Ignored bits never steer the result target outside byte group.
        acc_next    = (f.group == GRP_BYTE) && !f.target;
        freg_next   = (f.group == GRP_BYTE) && f.target;
        index_next  = f.index;
        pos_next    = f.position;
        imm_next    = f.constant;
        pcl_next    = f.is_branch || f.is_call;
        two_next    = pcl_next;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_reg     <= '0;
      flush_reg     <= 1'b1;
      group_reg     <= GRP_LIT;
      opcode_reg    <= '0;
      acc_reg       <= 1'b0;
      freg_reg      <= 1'b0;
      index_reg     <= '0;
      pos_reg       <= '0;
      imm_reg       <= '0;
      two_reg       <= 1'b0;
      pcl_reg       <= 1'b0;
    end else begin
      phase_reg     <= phase_next;
      flush_reg     <= flush_next;
      group_reg     <= group_next;
      opcode_reg    <= opcode_next;
      acc_reg       <= acc_next;
      freg_reg      <= freg_next;
      index_reg     <= index_next;
      pos_reg       <= pos_next;
      imm_reg       <= imm_next;
      two_reg       <= two_next;
      pcl_reg       <= pcl_next;
    end
  end

  assign group_code   = group_reg;
  assign opcode       = opcode_reg;
  assign to_accum     = acc_reg;
  assign to_register  = freg_reg;
  assign reg_index    = index_reg;
  assign bit_position = pos_reg;
  assign immediate    = imm_reg;
  assign two_cycle    = two_reg;
  assign pc_load      = pcl_reg;
  assign idle_cycle   = flush_reg;
  assign cycle_start  = (phase_reg == '0);

  sequence s_cycle_end;
    phase_reg == PHASE_LAST;
  endsequence

  a_phase_four: assert property (@(posedge clk) disable iff (!rst_b)
    s_cycle_end |=> (phase_reg == '0) ##3 (phase_reg == PHASE_LAST))
    else $error("instruction cycle is not four periods");
  a_branch_idle: assert property (@(posedge clk) disable iff (!rst_b)
    (s_cycle_end and !flush_reg and pc_load) |=> idle_cycle [*4])
    else $error("branch not followed by idle cycle");
  a_target_excl: assert property (@(posedge clk) disable iff (!rst_b)
    !(to_accum && to_register))
    else $error("both targets selected");
  a_target_acc: assert property (@(posedge clk) disable iff (!rst_b)
    (s_cycle_end and !discard and
     f.group == GRP_BYTE and !f.target and !f.is_branch and !f.is_call)
    |=> to_accum)
    else $error("target zero did not select accumulator");
  a_index_range: assert property (@(posedge clk) disable iff (!rst_b)
    reg_index <= IDX_MAX)
    else $error("register index out of range");
  a_branch_k9: assert property (@(posedge clk) disable iff (!rst_b)
    (s_cycle_end and !discard and f.is_branch)
    |=> immediate == $past(instr_word[8:0]))
    else $error("branch constant wrong");
  a_lit_k8: assert property (@(posedge clk) disable iff (!rst_b)
    (s_cycle_end and !discard and f.group == GRP_LIT
     and !f.is_branch and !f.is_call) |=> immediate == {1'b0, $past(instr_word[7:0])})
    else $error("literal constant wrong");
  a_bit_pos: assert property (@(posedge clk) disable iff (!rst_b)
    (s_cycle_end and !discard and f.group == GRP_BIT)
    |=> bit_position == $past(instr_word[7:5]) && group_code == GRP_BIT)
    else $error("bit position wrong");
  a_skip_two: assert property (@(posedge clk) disable iff (!rst_b)
    (s_cycle_end and skip_true and !flush_reg and group_reg == GRP_BIT)
    |=> idle_cycle [*4])
    else $error("true test did not add a cycle");
endmodule
